// file: rtl/cascaded_divider_duty_correction.sv
// channel divider: optional prescaler, two cascaded stages, duty fix
//
// How it works
// (R01) With duty fix, an even stage is programmed with low count equal to high.
// (R02) With duty fix, an odd stage is programmed with low count one above high.
// (R03) If one stage alone is bypassed, software bypasses the second one.
// (R04) If one stage alone is even, software makes the second one even.
// (R05) No fix, prescaler only: even ratio 50%, ratio 3 33.3%, ratio 5 40%.
// (R06) No fix: high lasts high count plus one; last active stage sets duty.
// (R07) No fix, no prescaler, both bypassed: input duty passes unchanged.
// (R08) Fix on with 50% source: output is 50% for all legal settings.
// (R09) Fix on, stages bypassed: odd ratio 3 or 5 keeps part of input duty.
// (R10) Fix on: any even ratio or even stage gives exactly 50% output.
// (R11) Count fields hold cycles minus one; stage division is high+low+2.
// (R12) Channel division is the product of stage divisions, at most 1024.
// (R13) Duty fix is on after reset; the disable input set to one turns it off.
// (R14) Stage two runs off stage one's output; counts reload each period.
// (R15) Odd stages with fix drop their output on the next opposite input edge.
module cascaded_divider_duty_correction (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // divider input clock, from a pin
    input wire logic div_in_clk_i,
    // prescaler settings
    input wire logic vco_div_used_i,
    input wire logic [duty_div_pkg::RATIO_W-1:0] vco_ratio_i,
    // stage settings
    input duty_div_pkg::stage_cfg_t stage1_cfg_i,
    input duty_div_pkg::stage_cfg_t stage2_cfg_i,
    input wire logic duty_fix_disable_i,
    // divided clock and status
    output logic div_out_o,
    output logic [duty_div_pkg::CHAN_DIV_W-1:0] channel_div_o,
    output logic duty_fix_active_o
);

    // ------------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------------
    logic in_meta;
    logic in_sync;
    logic in_prev;
    duty_div_pkg::clk_track_t src_track;

    // the edge detector only looks at the second and third flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
            in_prev <= 1'b0;
        end else begin
            in_meta <= div_in_clk_i;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end

    always_comb begin
        src_track.level = in_sync;
        src_track.rise = in_sync & ~in_prev;
        src_track.fall = ~in_sync & in_prev;
    end

    // ------------------------------------------------------------------
    // duty fix enable
    // ------------------------------------------------------------------
    logic duty_fix_en;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            duty_fix_en <= duty_div_pkg::DUTY_FIX_EN_RST; // R13
        end else begin
            duty_fix_en <= ~duty_fix_disable_i; // R13
        end
    end

    // ------------------------------------------------------------------
    // prescaler as a stage: ratio r gives high (r/2)-1, low the rest
    // ------------------------------------------------------------------
    logic [duty_div_pkg::RATIO_W-1:0] vco_high;
    logic [duty_div_pkg::RATIO_W-1:0] vco_low;
    duty_div_pkg::stage_cfg_t vco_cfg;

    // odd ratios put the extra cycle into the low part: 3 -> 1/3, 5 -> 2/5
    always_comb begin
        vco_high = (vco_ratio_i >> 1) - 3'h1; // R05
        vco_low = vco_ratio_i - duty_div_pkg::VCO_RATIO_OFFSET - vco_high; // R05
        vco_cfg.high_cnt = {1'b0, vco_high};
        vco_cfg.low_cnt = {1'b0, vco_low};
        vco_cfg.bypass = ~vco_div_used_i;
    end

    duty_div_pkg::clk_track_t vco_track;
    duty_div_pkg::clk_track_t st1_track;
    duty_div_pkg::clk_track_t st2_track;

    // the prescaler gets the same late-fall fix, giving (1+X)/3 and (2+X)/5
    divider_stage u_vco_div (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_i(src_track),
        .cfg_i(vco_cfg),
        .duty_fix_i(duty_fix_en), // R09
        .out_o(vco_track)
    );

    // ------------------------------------------------------------------
    // cascaded stages
    // ------------------------------------------------------------------
    divider_stage u_stage1 (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_i(vco_track),
        .cfg_i(stage1_cfg_i),
        .duty_fix_i(duty_fix_en), // R08
        .out_o(st1_track)
    );

    // stage two sees stage one's output, or its input when bypassed
    divider_stage u_stage2 (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_i(st1_track), // R14
        .cfg_i(stage2_cfg_i),
        .duty_fix_i(duty_fix_en), // R10
        .out_o(st2_track)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [duty_div_pkg::STAGE_DIV_W-1:0] st1_div;
    logic [duty_div_pkg::STAGE_DIV_W-1:0] st2_div;
    logic [duty_div_pkg::CHAN_DIV_W-1:0] next_channel_div;

    always_comb begin
        st1_div = stage1_cfg_i.bypass ? duty_div_pkg::STAGE_DIV_BYPASS
            : ({2'h0, stage1_cfg_i.high_cnt} + {2'h0, stage1_cfg_i.low_cnt}
               + duty_div_pkg::STAGE_DIV_OFFSET); // R11
        st2_div = stage2_cfg_i.bypass ? duty_div_pkg::STAGE_DIV_BYPASS
            : ({2'h0, stage2_cfg_i.high_cnt} + {2'h0, stage2_cfg_i.low_cnt}
               + duty_div_pkg::STAGE_DIV_OFFSET); // R11
        // 32 x 32 is the largest product, which fits in eleven bits
        next_channel_div = 11'(st1_div * st2_div); // R12
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_out_o <= 1'b0;
        end else begin
            div_out_o <= st2_track.level; // R06
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            channel_div_o <= duty_div_pkg::CHAN_DIV_RST;
            duty_fix_active_o <= duty_div_pkg::DUTY_FIX_EN_RST;
        end else begin
            channel_div_o <= next_channel_div; // R12
            duty_fix_active_o <= duty_fix_en;
        end
    end

endmodule : cascaded_divider_duty_correction

// file: rtl/divider_stage.sv
// one programmable high/low divider stage with optional duty fix
module divider_stage (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // upstream divided clock and settings
    input duty_div_pkg::clk_track_t in_i,
    input duty_div_pkg::stage_cfg_t cfg_i,
    input wire logic duty_fix_i,
    // divided clock to the next stage
    output duty_div_pkg::clk_track_t out_o
);

    duty_div_pkg::phase_t phase;
    logic [duty_div_pkg::CNT_W-1:0] cnt;
    logic [duty_div_pkg::CNT_W-1:0] high_sh;
    logic [duty_div_pkg::CNT_W-1:0] low_sh;
    logic fix_sh;
    logic fall_pend;

    // counts advance on upstream rising edges only; the late fall of an
    // odd stage rides on the upstream falling edge, one upstream high time later
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            phase <= duty_div_pkg::PH_LOW;
            cnt <= duty_div_pkg::CNT_RST;
            high_sh <= duty_div_pkg::CNT_RST;
            low_sh <= duty_div_pkg::CNT_RST;
            fix_sh <= 1'b0;
            fall_pend <= 1'b0;
            out_o <= '0;
        end else if (cfg_i.bypass) begin
            out_o <= in_i; // R07
            phase <= duty_div_pkg::PH_LOW;
            cnt <= duty_div_pkg::CNT_RST;
            high_sh <= duty_div_pkg::CNT_RST;
            low_sh <= duty_div_pkg::CNT_RST;
            fix_sh <= 1'b0;
            fall_pend <= 1'b0;
        end else begin
            out_o.rise <= 1'b0;
            out_o.fall <= 1'b0;
            if (fall_pend && in_i.fall) begin
                fall_pend <= 1'b0; // R15
                out_o.level <= 1'b0;
                out_o.fall <= 1'b1;
            end
            if (in_i.rise) begin
                case (phase)
                    duty_div_pkg::PH_LOW: begin
                        if (cnt == low_sh) begin
                            // period boundary: take fresh counts
                            phase <= duty_div_pkg::PH_HIGH;
                            cnt <= duty_div_pkg::CNT_RST;
                            high_sh <= cfg_i.high_cnt; // R14
                            low_sh <= cfg_i.low_cnt; // R14
                            fix_sh <= duty_fix_i & (cfg_i.high_cnt[0] ^ cfg_i.low_cnt[0]); // R15
                            fall_pend <= 1'b0;
                            out_o.level <= 1'b1;
                            out_o.rise <= 1'b1;
                        end else begin
                            cnt <= cnt + duty_div_pkg::CNT_ONE; // R11
                        end
                    end
                    duty_div_pkg::PH_HIGH: begin
                        if (cnt == high_sh) begin
                            phase <= duty_div_pkg::PH_LOW;
                            cnt <= duty_div_pkg::CNT_RST;
                            if (fix_sh) begin
                                fall_pend <= 1'b1; // R15
                            end else begin
                                out_o.level <= 1'b0; // R06
                                out_o.fall <= 1'b1;
                            end
                        end else begin
                            cnt <= cnt + duty_div_pkg::CNT_ONE; // R11
                        end
                    end
                    default: begin
                        phase <= duty_div_pkg::PH_LOW;
                    end
                endcase
            end
        end
    end

endmodule : divider_stage

// file: rtl/duty_div_pkg.sv
// shared types and constants for the cascaded duty-corrected divider
package duty_div_pkg;

    // ------------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam int RATIO_W = 3;
    localparam int STAGE_DIV_W = 6;
    localparam int CHAN_DIV_W = 11;

    // ------------------------------------------------------------------
    // values after reset and fixed figures
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [STAGE_DIV_W-1:0] STAGE_DIV_BYPASS = 6'h01;
    localparam logic [STAGE_DIV_W-1:0] STAGE_DIV_OFFSET = 6'h02;
    localparam logic [CHAN_DIV_W-1:0] CHAN_DIV_RST = 11'h001;
    localparam logic [CHAN_DIV_W-1:0] CHAN_DIV_MAX = 11'h400;
    localparam logic DUTY_FIX_EN_RST = 1'b1;
    localparam logic [RATIO_W-1:0] VCO_RATIO_OFFSET = 3'h2;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // a divided clock as seen on the system clock: level plus edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } clk_track_t;

    // one stage's programming; counts hold cycles minus one
    typedef struct packed {
        logic [CNT_W-1:0] high_cnt;
        logic [CNT_W-1:0] low_cnt;
        logic bypass;
    } stage_cfg_t;

    typedef enum logic {
        PH_LOW,
        PH_HIGH
    } phase_t;

endpackage : duty_div_pkg

// file: verif/divider_checker_assertions.sv
// concurrent checks on the ports of the cascaded duty-corrected divider
module divider_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // inputs
    input wire logic div_in_clk_i,
    input wire logic vco_div_used_i,
    input wire logic [duty_div_pkg::RATIO_W-1:0] vco_ratio_i,
    input duty_div_pkg::stage_cfg_t stage1_cfg_i,
    input duty_div_pkg::stage_cfg_t stage2_cfg_i,
    input wire logic duty_fix_disable_i,
    // outputs
    input wire logic div_out_o,
    input wire logic [duty_div_pkg::CHAN_DIV_W-1:0] channel_div_o,
    input wire logic duty_fix_active_o
);
    logic [duty_div_pkg::CHAN_DIV_W-1:0] d1, d2, exp_div;
    logic [7:0] since_rise, since_fall;
    logic in_q;
    logic pass_mode;
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    assign d1 = stage1_cfg_i.bypass ? 11'h001 :
        11'(stage1_cfg_i.high_cnt) + 11'(stage1_cfg_i.low_cnt) + 11'h002;
    assign d2 = stage2_cfg_i.bypass ? 11'h001 :
        11'(stage2_cfg_i.high_cnt) + 11'(stage2_cfg_i.low_cnt) + 11'h002;
    assign exp_div = 11'(d1 * d2);
    assign pass_mode = !vco_div_used_i && stage1_cfg_i.bypass && stage2_cfg_i.bypass;
    // saturating ages of the last input edges, to tie output edges to causes
    always_ff @(posedge sys_clk_i) begin
        in_q <= div_in_clk_i;
        since_rise <= (div_in_clk_i && !in_q) ? 8'h00 : since_rise + 8'(since_rise != 8'hFF);
        since_fall <= (!div_in_clk_i && in_q) ? 8'h00 : since_fall + 8'(since_fall != 8'hFF);
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    sequence s_out_rise;
        $rose(div_out_o);
    endsequence
    sequence s_out_fall;
        $fell(div_out_o);
    endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_reset_values: assert property (disable iff (1'b0) !rst_n_i |=> !div_out_o &&
        channel_div_o == duty_div_pkg::CHAN_DIV_RST && duty_fix_active_o)
        else $error("outputs wrong after reset");
    a_fix_follows: assert property (disable iff (!rst_n_i)
        $past(rst_n_i) |=> duty_fix_active_o == !$past(duty_fix_disable_i, 2))
        else $error("duty fix status does not follow disable input");
    a_div_product: assert property (disable iff (!rst_n_i)
        1'b1 |=> channel_div_o == $past(exp_div))
        else $error("channel division is not the stage product");
    a_div_limit: assert property (disable iff (!rst_n_i)
        channel_div_o <= duty_div_pkg::CHAN_DIV_MAX && channel_div_o != 11'h000)
        else $error("channel division out of range");
    a_quiet_hold: assert property (disable iff (!rst_n_i)
        since_rise >= 8'd16 && since_fall >= 8'd16 |-> $stable(div_out_o))
        else $error("output moved with no input edge");
    a_rise_cause: assert property (disable iff (!rst_n_i)
        s_out_rise |-> since_rise <= 8'd10)
        else $error("output rose away from an input rising edge");
    a_fall_cause: assert property (disable iff (!rst_n_i)
        s_out_fall |-> since_rise <= 8'd10 || since_fall <= 8'd10)
        else $error("output fell away from any input edge");
    a_nofix_fall: assert property (disable iff (!rst_n_i)
        !duty_fix_active_o && !pass_mode ##0 s_out_fall |-> since_rise <= 8'd10)
        else $error("output fell on a falling input edge with fix off");
endmodule : divider_checker

// file: verif/testbench.sv
// self-checking bench for the cascaded duty-corrected divider
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic div_in_clk_i = 1'b0;
    logic vco_div_used_i = 1'b0;
    logic [duty_div_pkg::RATIO_W-1:0] vco_ratio_i = 3'h2;
    duty_div_pkg::stage_cfg_t stage1_cfg_i = '0;
    duty_div_pkg::stage_cfg_t stage2_cfg_i = '0;
    logic duty_fix_disable_i = 1'b0;
    logic div_out_o;
    logic [duty_div_pkg::CHAN_DIV_W-1:0] channel_div_o;
    logic duty_fix_active_o;
    int err_count = 0;
    int cmp_count = 0;
    int in_hi = 8;
    int rises = 0;
    int hi_c = 0;
    int per_c = 0;
    logic run = 1'b0;
    logic last = 1'b0;
    logic [43:0] exp_q[$];
    cascaded_divider_duty_correction uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .div_in_clk_i(div_in_clk_i), .vco_div_used_i(vco_div_used_i),
        .vco_ratio_i(vco_ratio_i), .stage1_cfg_i(stage1_cfg_i), .stage2_cfg_i(stage2_cfg_i),
        .duty_fix_disable_i(duty_fix_disable_i), .div_out_o(div_out_o),
        .channel_div_o(channel_div_o), .duty_fix_active_o(duty_fix_active_o));
    always #2 sys_clk_i = ~sys_clk_i;
    // input clock: 16 system cycles a period, high time in_hi; still when idle
    always begin
        @(negedge sys_clk_i);
        if (run) begin
            div_in_clk_i = 1'b1;
            repeat (in_hi) @(negedge sys_clk_i);
            div_in_clk_i = 1'b0;
            repeat (15 - in_hi) @(negedge sys_clk_i);
        end
    end
    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // ideal stage: high in upstream periods, odd stage with fix adds upstream high
    function automatic void stg(inout int h, inout int p, input int n, input int m,
            input logic b, input logic f);
        if (!b) begin
            h = (f && ((n + m) % 2 == 1)) ? (n + 1) * p + h : (n + 1) * p;
            p = (n + m + 2) * p;
        end
    endfunction : stg
    task automatic run_case(input logic u, input int r, input int n1, input int m1,
            input logic b1, input int n2, input int m2, input logic b2, input logic dis,
            input int ih);
        int h, p, c, ch;
        @(negedge sys_clk_i);
        run = 1'b0;
        // let the input clock finish its period: a pin still high at release
        // would give an edge that the checker never saw
        repeat (16) @(negedge sys_clk_i);
        rst_n_i = 1'b0;
        vco_div_used_i = u;
        vco_ratio_i = 3'(r);
        stage1_cfg_i = '{4'(n1), 4'(m1), b1};
        stage2_cfg_i = '{4'(n2), 4'(m2), b2};
        duty_fix_disable_i = dis;
        in_hi = ih;
        repeat (8) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        h = ih;
        p = 16;
        if (u) stg(h, p, r / 2 - 1, r - 2 - (r / 2 - 1), 1'b0, !dis);
        stg(h, p, n1, m1, b1, !dis);
        stg(h, p, n2, m2, b2, !dis);
        ch = (b1 ? 1 : n1 + m1 + 2) * (b2 ? 1 : n2 + m2 + 2);
        exp_q.push_back({11'(ch), !dis, 16'(h), 16'(p)});
        run = 1'b1;
        c = 0;
        while (exp_q.size() > 0 && c < 20000) begin
            @(negedge sys_clk_i);
            c++;
        end
        if (c >= 20000) begin
            err_count++;
            $display("ERROR %0t: no divided clock", $time);
            stop_test();
        end
        run = 1'b0;
        $display("test done: ratio %0d high %0d period %0d", r, h, p);
    endtask : run_case
    // watcher: measures one full output period after two settling rises
    always @(posedge sys_clk_i) begin
        if (!run) begin
            rises = 0;
        end else if (div_out_o === 1'b1 && last !== 1'b1) begin
            if (rises >= 2 && exp_q.size() > 0)
                check({channel_div_o, duty_fix_active_o, 16'(hi_c), 16'(per_c)},
                    exp_q.pop_front());
            rises++;
            hi_c = 1;
            per_c = 1;
        end else begin
            per_c++;
            if (div_out_o === 1'b1) hi_c++;
        end
        last = div_out_o;
    end
    initial begin
        int a, b;
        void'($urandom(32'hA8DB517E));
        for (int r = 2; r <= 6; r++) run_case(1'b1, r, 0, 0, 1'b1, 0, 0, 1'b1, 1'b1, 8);
        run_case(1'b0, 2, 0, 0, 1'b1, 0, 0, 1'b1, 1'b1, 5);
        run_case(1'b0, 2, 2, 0, 1'b0, 0, 0, 1'b1, 1'b1, 8);
        run_case(1'b1, 3, 1, 2, 1'b0, 0, 2, 1'b0, 1'b1, 8);
        run_case(1'b1, 3, 0, 0, 1'b1, 0, 0, 1'b1, 1'b0, 4);
        run_case(1'b1, 5, 0, 0, 1'b1, 0, 0, 1'b1, 1'b0, 4);
        run_case(1'b1, 3, 0, 1, 1'b0, 1, 1, 1'b0, 1'b0, 8);
        run_case(1'b0, 2, 1, 2, 1'b0, 0, 0, 1'b0, 1'b0, 5);
        run_case(1'b0, 2, 0, 1, 1'b0, 1, 2, 1'b0, 1'b0, 8);
        for (int i = 0; i < 2; i++) begin
            a = $urandom_range(0, 2);
            b = $urandom_range(0, 2);
            run_case(1'b1, 2 + $urandom_range(0, 4), a, a + $urandom_range(0, 1), 1'b0,
                b, b + $urandom_range(0, 1), 1'b0, 1'($urandom_range(0, 1)),
                3 + $urandom_range(0, 10));
        end
        stop_test();
    end
endmodule : testbench
bind cascaded_divider_duty_correction divider_checker chk (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .div_in_clk_i(div_in_clk_i), .vco_div_used_i(vco_div_used_i),
    .vco_ratio_i(vco_ratio_i), .stage1_cfg_i(stage1_cfg_i), .stage2_cfg_i(stage2_cfg_i),
    .duty_fix_disable_i(duty_fix_disable_i), .div_out_o(div_out_o),
    .channel_div_o(channel_div_o), .duty_fix_active_o(duty_fix_active_o));
